/* File: common/tgc_pkg.sv */
// Shared constants and types for the timer gate control block.
// Assumes a 32-bit AHB-Lite register bus, one register per aligned word.

`default_nettype none

package tgc_pkg;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_GATE_CTL = 8'h00; // Gate control
   localparam logic [7:0] OFS_RUN_CTL = 8'h04;  // Counter on
   localparam logic [7:0] OFS_IRQ_STS = 8'h08;  // Sticky events, W1C
   localparam logic [7:0] OFS_IRQ_MSK = 8'h0C;  // Interrupt mask

   // ----------------------------------------
   // Field positions: gate control, run control and event bits
   // ----------------------------------------
   localparam int BIT_GATE_EN = 7;     // Gate enable
   localparam int BIT_GATE_POL = 6;    // Gate polarity
   localparam int BIT_TOGGLE = 5;      // Toggle mode
   localparam int BIT_SPM = 4;         // Single-pulse mode
   localparam int BIT_ARMED = 3;       // Single-pulse armed
   localparam int BIT_LEVEL = 2;       // Live gate level, read only
   localparam int BIT_RUN_ON = 0;      // Counter on, in run control
   localparam int EVT_SP_DONE = 0;     // Event: acquisition done
   localparam int EVT_GATE_RISE = 1;   // Event: effective gate rose
   localparam int NUM_EVT = 2;         // Number of event bits

   // ----------------------------------------
   // Reset values and source codes
   // ----------------------------------------
   localparam logic [7:0] RST_GATE_CTL = 8'h00;
   localparam logic RST_RUN_ON = 1'b0;
   localparam logic [1:0] RST_EVT = 2'h0;
   localparam logic [1:0] SRC_PIN = 2'h0;    // Gate pin
   localparam logic [1:0] SRC_OVF = 2'h1;    // Other timer overflow
   localparam logic [1:0] SRC_MATCH = 2'h2;  // Third timer period match

   // Writable gate control fields
   typedef struct packed {
      logic gate_enable_ctl;
      logic gate_polarity;
      logic gate_toggle_mode;
      logic gate_single_pulse_mode;
      logic [1:0] gate_source_select;
   } tgc_cfg_s;

   // Candidate gate sources
   typedef struct packed {
      logic pin;
      logic ovf;
      logic match;
   } tgc_src_s;

endpackage

`default_nettype wire

/* File: rtl/tgc_sync.sv */
// Two-flop synchroniser, one chain per bit.
// Assumes inputs are asynchronous to clk; first stage is read only by the second.

`timescale 1ns/1ps
`default_nettype none

module tgc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   // Width must be usable
   if (W < 1) begin : g_chk
      $error("tgc_sync width must be at least one");
   end

   // ----------------------------------------
   // One chain per bit
   // ----------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_q; // First stage, read only by the second
      // Two stages, constant reset
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_q <= 1'b0;
            q[i] <= 1'b0;
         end else begin
            meta_q <= d[i];
            q[i] <= meta_q;
         end
      end
   end

endmodule

`default_nettype wire

/* File: rtl/tgc_single_pulse.sv */
// Single-pulse acquisition sequencer for the timer gate.
// Assumes gate_in is already synchronous and shaped by polarity and toggle.

`timescale 1ns/1ps
`default_nettype none

module tgc_single_pulse (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic spm,
   input wire logic arm_set,
   input wire logic arm_clr,
   input wire logic gate_in,
   output logic armed,
   output logic active,
   output logic done
);

   // Gray-coded sequence: idle, waiting, counting
   typedef enum logic [1:0] {
      SP_IDLE = 2'b00,
      SP_WAIT = 2'b01,
      SP_RUN = 2'b11
   } tgc_sp_e;

   tgc_sp_e state_q; // Sequencer state
   logic gate_prev_q; // Gate one cycle ago
   logic rise;
   logic fall;

   assign rise = gate_in & ~gate_prev_q;
   assign fall = ~gate_in & gate_prev_q;

   // ----------------------------------------
   // Edge history
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_prev_q <= 1'b0;
      end else begin
         gate_prev_q <= gate_in;
      end
   end

   // ----------------------------------------
   // Sequencer; leaving the mode aborts
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SP_IDLE;
      end else if (!spm || arm_clr) begin
         state_q <= SP_IDLE;
      end else begin
         case (state_q)
            SP_IDLE: begin
               if (arm_set) begin
                  state_q <= SP_WAIT;
               end
            end
            // Only a fresh edge starts, a high level does not
            SP_WAIT: begin
               if (rise) begin
                  state_q <= SP_RUN;
               end
            end
            // One pulse only, then back to idle
            SP_RUN: begin
               if (fall) begin
                  state_q <= SP_IDLE;
               end
            end
            default: begin
               state_q <= SP_IDLE;
            end
         endcase
      end
   end

   // Armed while an acquisition is pending or running
   assign armed = (state_q != SP_IDLE);
   // Gate open only inside the captured pulse
   assign active = (state_q == SP_RUN) & gate_in;
   // Completion pulse, one cycle
   assign done = spm & ~arm_clr & (state_q == SP_RUN) & fall;

endmodule

`default_nettype wire

/* File: rtl/tgc_top.sv */
// Timer gate control with AHB-Lite register slave.
// Assumes overflow and period-match inputs share clk_sys; gate pin is async.
//
// Functional notes
// - Polarity picks counting on high or low
// - Toggle mode off holds toggle flop cleared
// - Toggle flop inverts on each gate rising edge
// - Single-pulse mode takes control of gate
// - Armed bit set by software, hardware clears
// - Level bit shows gate, ignores gate enable
// - Source 00 pin, 01 overflow, 10 match

`timescale 1ns/1ps
`default_nettype none

module tgc_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Gate sources
   input wire logic gate_pin,
   input wire logic tmr_overflow_in,
   input wire logic period_match_in,
   // Counter core and interrupt
   output logic count_en,
   output logic gate_level,
   output logic irq
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_q; // First reset stage
   logic rst_sync_q; // Released reset for the block
   logic rst_int_n;

   // Async assert, synchronous release
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign rst_int_n = rst_sync_q;

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   tgc_pkg::tgc_cfg_s cfg_q; // Writable gate control fields
   logic counter_on_q; // Counter switched on
   logic [tgc_pkg::NUM_EVT-1:0] sts_q; // Sticky events
   logic [tgc_pkg::NUM_EVT-1:0] msk_q; // Interrupt mask

   // ----------------------------------------
   // AHB-Lite transfer tracking
   // ----------------------------------------
   logic accept; // Address phase taken
   logic wr_pend_q; // Write data phase open
   logic rd_pend_q; // Read waits one cycle
   logic [7:0] addr_q; // Captured byte offset
   logic wr_en; // Write strobe in data phase
   logic [31:0] rdata_q; // Registered read data
   logic [31:0] rd_mux; // Read value selected

   // Taken only on NONSEQ or SEQ with bus ready
   assign accept = hsel & hready & htrans[1];

   // Read uses one wait state so a write just before is seen
   assign hreadyout = ~rd_pend_q;
   // Always OKAY
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   // Address phase capture
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         addr_q <= 8'h00;
         wr_pend_q <= 1'b0;
      end else if (hready) begin
         wr_pend_q <= accept & hwrite;
         if (accept) begin
            addr_q <= {haddr[7:2], 2'b00};
         end
      end
   end

   // Read wait-state flag
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         rd_pend_q <= 1'b0;
      end else begin
         rd_pend_q <= accept & ~hwrite;
      end
   end

   // Any taken write strobes; only haddr[7:2] decode, so every page aliases
   assign wr_en = wr_pend_q;

   // ----------------------------------------
   // Gate path signals
   // ----------------------------------------
   tgc_pkg::tgc_src_s src; // Source bundle
   logic pin_sync; // Synchronised pin
   logic gate_sel; // Chosen source
   logic gate_pol; // Polarity adjusted
   logic gate_pol_prev_q; // For edge detect
   logic toggle_q; // Toggle flop
   logic gate_shaped; // After toggle stage
   logic gate_eff; // Gate offered to counter
   logic gate_eff_prev_q; // For event edge
   logic sp_armed;
   logic sp_active;
   logic sp_done;
   logic arm_set;
   logic arm_clr;
   logic ctl_wr;

   // The pin is asynchronous, so it crosses first
   tgc_sync #(
      .W(1)
   ) u_pin_sync (
      .clk(clk_sys),
      .rst_n(rst_int_n),
      .d(gate_pin),
      .q(pin_sync)
   );

   // Same-clock sources pass straight in
   assign src.pin = pin_sync;
   assign src.ovf = tmr_overflow_in;
   assign src.match = period_match_in;

   // Source select; reserved code selects a low level, which polarity 0 opens
   always_comb begin
      case (cfg_q.gate_source_select)
         tgc_pkg::SRC_PIN: gate_sel = src.pin;
         tgc_pkg::SRC_OVF: gate_sel = src.ovf;
         tgc_pkg::SRC_MATCH: gate_sel = src.match;
         default: gate_sel = 1'b0;
      endcase
   end

   // Polarity 1 counts on high, 0 counts on low
   assign gate_pol = cfg_q.gate_polarity ? gate_sel : ~gate_sel;

   // Edge history of the adjusted gate
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         gate_pol_prev_q <= 1'b0;
      end else begin
         gate_pol_prev_q <= gate_pol;
      end
   end

   // ----------------------------------------
   // Toggle stage
   // ----------------------------------------
   // Held clear when the mode is off
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         toggle_q <= 1'b0;
      end else if (!cfg_q.gate_toggle_mode) begin
         toggle_q <= 1'b0;
      end else if (gate_pol & ~gate_pol_prev_q) begin
         toggle_q <= ~toggle_q;
      end
   end

   // Flop output replaces the gate in toggle mode
   assign gate_shaped = cfg_q.gate_toggle_mode ? toggle_q : gate_pol;

   // ----------------------------------------
   // Single-pulse stage
   // ----------------------------------------
   assign ctl_wr = wr_en & (addr_q == tgc_pkg::OFS_GATE_CTL);
   // Arming needs the mode set in the same write
   assign arm_set = ctl_wr & hwdata[tgc_pkg::BIT_ARMED]
                    & hwdata[tgc_pkg::BIT_SPM];
   // Writing zero abandons a pending acquisition
   assign arm_clr = ctl_wr & ~hwdata[tgc_pkg::BIT_ARMED];
   // Mode as it will stand after a write in flight, so one write can enable and arm
   logic spm_now;
   assign spm_now = ctl_wr ? hwdata[tgc_pkg::BIT_SPM] : cfg_q.gate_single_pulse_mode;

   tgc_single_pulse u_single_pulse (
      .clk(clk_sys),
      .rst_n(rst_int_n),
      .spm(spm_now),
      .arm_set(arm_set),
      .arm_clr(arm_clr),
      .gate_in(gate_shaped),
      .armed(sp_armed),
      .active(sp_active),
      .done(sp_done)
   );

   // Single-pulse logic owns the gate when enabled
   assign gate_eff = cfg_q.gate_single_pulse_mode ? sp_active : gate_shaped;

   // Live level, independent of gate enable
   assign gate_level = gate_eff;

   // Counter runs only when on; gate used only if enabled
   assign count_en = counter_on_q
                     & (cfg_q.gate_enable_ctl ? gate_eff : 1'b1);

   // ----------------------------------------
   // Configuration writes
   // ----------------------------------------
   // Gate control fields; level and armed are not stored here
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         cfg_q <= '0;
      end else if (ctl_wr) begin
         cfg_q.gate_enable_ctl <= hwdata[tgc_pkg::BIT_GATE_EN];
         cfg_q.gate_polarity <= hwdata[tgc_pkg::BIT_GATE_POL];
         cfg_q.gate_toggle_mode <= hwdata[tgc_pkg::BIT_TOGGLE];
         cfg_q.gate_single_pulse_mode <= hwdata[tgc_pkg::BIT_SPM];
         cfg_q.gate_source_select <= hwdata[1:0];
      end
   end

   // Counter on bit
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         counter_on_q <= tgc_pkg::RST_RUN_ON;
      end else if (wr_en && addr_q == tgc_pkg::OFS_RUN_CTL) begin
         counter_on_q <= hwdata[tgc_pkg::BIT_RUN_ON];
      end
   end

   // Mask register
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         msk_q <= tgc_pkg::RST_EVT;
      end else if (wr_en && addr_q == tgc_pkg::OFS_IRQ_MSK) begin
         msk_q <= hwdata[tgc_pkg::NUM_EVT-1:0];
      end
   end

   // ----------------------------------------
   // Events and interrupt
   // ----------------------------------------
   logic [tgc_pkg::NUM_EVT-1:0] evt;
   logic [tgc_pkg::NUM_EVT-1:0] w1c;

   // Effective gate history for the rise event
   // Reset gate is open (polarity 0, idle source), so history starts high: no false edge
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         gate_eff_prev_q <= 1'b1;
      end else begin
         gate_eff_prev_q <= gate_eff;
      end
   end

   assign evt[tgc_pkg::EVT_SP_DONE] = sp_done;
   assign evt[tgc_pkg::EVT_GATE_RISE] = gate_eff & ~gate_eff_prev_q;
   assign w1c = (wr_en && addr_q == tgc_pkg::OFS_IRQ_STS)
                ? hwdata[tgc_pkg::NUM_EVT-1:0] : '0;

   // Sticky bits; a new event beats a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         sts_q <= tgc_pkg::RST_EVT;
      end else begin
         sts_q <= (sts_q & ~w1c) | evt;
      end
   end

   // Level output, high while any unmasked bit stands
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |((sts_q & ~w1c | evt) & msk_q);
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (addr_q)
         tgc_pkg::OFS_GATE_CTL: begin
            rd_mux[tgc_pkg::BIT_GATE_EN] = cfg_q.gate_enable_ctl;
            rd_mux[tgc_pkg::BIT_GATE_POL] = cfg_q.gate_polarity;
            rd_mux[tgc_pkg::BIT_TOGGLE] = cfg_q.gate_toggle_mode;
            rd_mux[tgc_pkg::BIT_SPM] = cfg_q.gate_single_pulse_mode;
            rd_mux[tgc_pkg::BIT_ARMED] = sp_armed;
            rd_mux[tgc_pkg::BIT_LEVEL] = gate_eff;
            rd_mux[1:0] = cfg_q.gate_source_select;
         end
         tgc_pkg::OFS_RUN_CTL: begin
            rd_mux[tgc_pkg::BIT_RUN_ON] = counter_on_q;
         end
         tgc_pkg::OFS_IRQ_STS: begin
            rd_mux[tgc_pkg::NUM_EVT-1:0] = sts_q;
         end
         tgc_pkg::OFS_IRQ_MSK: begin
            rd_mux[tgc_pkg::NUM_EVT-1:0] = msk_q;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // Data sampled in the wait cycle, after any prior write landed
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_pend_q) begin
         rdata_q <= rd_mux;
      end
   end

   // Size is not checked; any size acts as a word
   logic unused_ok;
   assign unused_ok = ^{hsize, haddr[31:8], haddr[1:0], htrans[0]};

endmodule

`default_nettype wire

/* File: tb/tgc_chk.sv */
// Checker for the timer gate control top: bus timing and the gate path.
// Assumes one slave, so hready is this block's own hreadyout.
`timescale 1ns/1ps
`default_nettype none
module tgc_chk (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic gate_pin,
   input wire logic tmr_overflow_in,
   input wire logic period_match_in,
   input wire logic count_en,
   input wire logic gate_level
);
   // ----------------
   // Register shadow
   // ----------------
   logic wr_q; // Write in data phase
   logic [7:0] ofs_q; // Its offset
   logic [7:0] cfg_q; // Mirror of gate control
   logic run_q; // Mirror of counter on
   logic seen_q; // Control written since reset
   wire take = hsel && hready && htrans[1];
   wire ge = cfg_q[tgc_pkg::BIT_GATE_EN];
   wire pol = cfg_q[tgc_pkg::BIT_GATE_POL];
   wire tm = cfg_q[tgc_pkg::BIT_TOGGLE];
   wire plain = !tm && !cfg_q[tgc_pkg::BIT_SPM]; // Source reaches gate unshaped
   wire [1:0] src = cfg_q[1:0];
   // Remember a taken write so its data lands when the design's does
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= 1'h0;
         ofs_q <= 8'h00;
      end else if (hready) begin
         wr_q <= take && hwrite;
         ofs_q <= {haddr[7:2], 2'h0};
      end
   end
   // Mirror the writable fields; pin checks wait for a first write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= 8'h00;
         run_q <= 1'h0;
         seen_q <= 1'h0;
      end else if (wr_q && hready) begin
         if (ofs_q == tgc_pkg::OFS_GATE_CTL) begin
            cfg_q <= hwdata[7:0];
            seen_q <= 1'h1;
         end
         if (ofs_q == tgc_pkg::OFS_RUN_CTL) begin
            run_q <= hwdata[0];
         end
      end
   end
   // ----------------
   // Assertions
   // ----------------
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   chk_resp_okay: assert property (hresp == 1'h0)
      else $error("bus response not OKAY");
   chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_zero: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   chk_off_idle: assert property (!run_q |-> !count_en)
      else $error("count while counter off");
   chk_free_run: assert property (run_q && !ge |-> count_en)
      else $error("no count with gate unused");
   chk_gate_and: assert property (run_q && ge |-> count_en == gate_level)
      else $error("count enable differs from gate");
   chk_src_ovf: assert property (
      plain && src == tgc_pkg::SRC_OVF |-> gate_level == (tmr_overflow_in ~^ pol))
      else $error("overflow source gate wrong");
   chk_src_match: assert property (
      plain && src == tgc_pkg::SRC_MATCH |-> gate_level == (period_match_in ~^ pol))
      else $error("match source gate wrong");
   chk_src_pin: assert property (
      seen_q && plain && src == tgc_pkg::SRC_PIN && $stable(cfg_q)
      |-> gate_level == ($past(gate_pin, 2) ~^ pol))
      else $error("pin source gate wrong");
   chk_toggle_flip: assert property (
      tm && !cfg_q[tgc_pkg::BIT_SPM] && pol
      && src == tgc_pkg::SRC_OVF && $stable(cfg_q) && $rose(tmr_overflow_in)
      |=> gate_level != $past(gate_level))
      else $error("toggle gate did not flip");
endmodule
`default_nettype wire

/* File: tb/tgc_partner.sv */
// Far-side model: gate pin, sibling overflow and match, counter core.
// Assumes the bench picks which source is live and its level.
`timescale 1ns/1ps
`default_nettype none
module tgc_partner (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [1:0] sel,
   input wire logic lvl,
   input wire logic count_en,
   output logic gate_pin,
   output logic tmr_overflow_in,
   output logic period_match_in,
   output logic [15:0] counter_value
);
   // ----------------
   // Gate sources
   // ----------------
   // Unpicked sources carry the inverse level, so a wrong pick shows
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gate_pin <= 1'h0;
         tmr_overflow_in <= 1'h0;
         period_match_in <= 1'h0;
      end else begin
         gate_pin <= (sel == 2'h0) ? lvl : !lvl;
         tmr_overflow_in <= (sel == 2'h1) ? lvl : !lvl;
         period_match_in <= (sel == 2'h2) ? lvl : !lvl;
      end
   end
   // ----------------
   // Counter core
   // ----------------
   // One step per clock while enabled
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         counter_value <= 16'h0000;
      end else if (count_en) begin
         counter_value <= counter_value + 16'h0001;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tgc_top_tb.sv */
// Bench for the timer gate control top: bus tasks and gate scenarios.
// Assumes the far-side model drives all sources and counts increments.
`timescale 1ns/1ps
`default_nettype none
module tgc_top_tb;
   // ----------------
   // Signals
   // ----------------
   logic clk_sys = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, lvl = 1'h0, g;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0, sel = 2'h0;
   logic [2:0] hsize = 3'h2; // Whole words only
   logic hready, hreadyout, hresp, gate_pin, tmr_overflow_in, period_match_in;
   logic count_en, gate_level, irq;
   logic [15:0] cnt, c0;
   int fail_count = 0;
   int n_tests = 0;
   assign hready = hreadyout; // Single slave
   always #12.5 clk_sys = ~clk_sys; // 40 MHz
   tgc_top uut (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
      .hwdata, .hrdata, .hreadyout, .hresp, .gate_pin, .tmr_overflow_in,
      .period_match_in, .count_en, .gate_level, .irq);
   tgc_partner u_far (.clk_sys, .rst_n, .sel, .lvl, .count_en, .gate_pin,
      .tmr_overflow_in, .period_match_in, .counter_value(cnt));
   // ----------------
   // Tasks
   // ----------------
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Bounded wait for hready high at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk_sys);
      while (hreadyout !== 1'h1) begin
         n++;
         if (n > 20) begin
            fail_count++;
            stop_test();
         end
         @(posedge clk_sys);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'h1;
      wait_rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask
   // Read data is taken at the edge that ends the data phase
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'h0;
      wait_rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      wait_rdy();
      chk(hrdata, e);
   endtask
   // ----------------
   // Scenarios
   // ----------------
   initial begin
      cyc(10);
      rst_n <= 1'h1;
      cyc(3);
      // Reset values; pin low at polarity 0 shows an active gate level
      rd_chk(tgc_pkg::OFS_GATE_CTL, 32'h4);
      rd_chk(tgc_pkg::OFS_RUN_CTL, 32'h0);
      rd_chk(tgc_pkg::OFS_IRQ_STS, 32'h0);
      rd_chk(tgc_pkg::OFS_IRQ_MSK, 32'h0);
      ahb_wr(8'h10, 32'hFF);
      rd_chk(8'h10, 32'h0);
      // Counter off: gate enable has no effect
      ahb_wr(tgc_pkg::OFS_GATE_CTL, 32'h80);
      c0 = cnt;
      cyc(8);
      chk({16'h0, cnt - c0}, 32'h0);
      // Gate unused: counts with an inactive gate
      ahb_wr(tgc_pkg::OFS_RUN_CTL, 32'h1);
      ahb_wr(tgc_pkg::OFS_GATE_CTL, 32'h40);
      c0 = cnt;
      cyc(8);
      chk({16'h0, cnt - c0}, 32'h8);
      // Every source, polarity and level
      for (int s = 0; s < 3; s++) begin
         for (int p = 0; p < 2; p++) begin
            for (int l = 0; l < 2; l++) begin
               sel <= s[1:0];
               lvl <= l[0];
               ahb_wr(tgc_pkg::OFS_GATE_CTL, {24'h0, 1'h1, p[0], 4'h0, s[1:0]});
               cyc(4);
               g = l[0] ~^ p[0];
               chk_bit(gate_level, g);
               c0 = cnt;
               cyc(4);
               chk({16'h0, cnt - c0}, g ? 32'h4 : 32'h0);
               rd_chk(tgc_pkg::OFS_GATE_CTL, {24'h0, 1'h1, p[0], 3'h0, g, s[1:0]});
            end
         end
      end
      // Level bit ignores gate enable
      sel <= 2'h1;
      ahb_wr(tgc_pkg::OFS_GATE_CTL, 32'h41);
      cyc(3);
      rd_chk(tgc_pkg::OFS_GATE_CTL, 32'h45);
      // Reserved source gives no gate although the pin and match sources are high
      lvl <= 1'h0;
      ahb_wr(tgc_pkg::OFS_GATE_CTL, 32'hC3);
      cyc(3);
      rd_chk(tgc_pkg::OFS_GATE_CTL, 32'hC3);
      // Toggle mode flips on each rising edge
      ahb_wr(tgc_pkg::OFS_GATE_CTL, 32'hE1);
      cyc(3);
      chk_bit(gate_level, 1'h0);
      for (int k = 0; k < 3; k++) begin
         lvl <= 1'h1;
         cyc(3);
         lvl <= 1'h0;
         cyc(3);
         chk_bit(gate_level, !k[0]);
      end
      ahb_wr(tgc_pkg::OFS_GATE_CTL, 32'hC1);
      cyc(1);
      chk_bit(gate_level, 1'h0);
      ahb_wr(tgc_pkg::OFS_GATE_CTL, 32'hE1);
      cyc(1);
      chk_bit(gate_level, 1'h0);
      // Single pulse, armed, with done unmasked
      ahb_wr(tgc_pkg::OFS_IRQ_STS, 32'h3);
      ahb_wr(tgc_pkg::OFS_IRQ_MSK, 32'h1);
      ahb_wr(tgc_pkg::OFS_GATE_CTL, 32'hD9);
      rd_chk(tgc_pkg::OFS_GATE_CTL, 32'hD9);
      chk_bit(count_en, 1'h0);
      lvl <= 1'h1;
      cyc(3);
      chk_bit(count_en, 1'h1);
      lvl <= 1'h0;
      cyc(3);
      chk_bit(gate_level, 1'h0);
      rd_chk(tgc_pkg::OFS_GATE_CTL, 32'hD1);
      rd_chk(tgc_pkg::OFS_IRQ_STS, 32'h3);
      chk_bit(irq, 1'h1);
      ahb_wr(tgc_pkg::OFS_IRQ_STS, 32'h1);
      cyc(2);
      chk_bit(irq, 1'h0);
      rd_chk(tgc_pkg::OFS_IRQ_STS, 32'h2);
      // Not armed: a second pulse does not pass
      lvl <= 1'h1;
      cyc(3);
      chk_bit(gate_level, 1'h0);
      lvl <= 1'h0;
      // Masked done raises no interrupt until unmasked
      ahb_wr(tgc_pkg::OFS_IRQ_MSK, 32'h0);
      ahb_wr(tgc_pkg::OFS_GATE_CTL, 32'hD9);
      lvl <= 1'h1;
      cyc(3);
      lvl <= 1'h0;
      cyc(3);
      chk_bit(irq, 1'h0);
      ahb_wr(tgc_pkg::OFS_IRQ_MSK, 32'h1);
      cyc(2);
      chk_bit(irq, 1'h1);
      ahb_wr(tgc_pkg::OFS_IRQ_STS, 32'h3);
      cyc(2);
      chk_bit(irq, 1'h0);
      stop_test();
   end
endmodule
bind tgc_top tgc_chk u_chk (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hready,
   .hwdata, .hreadyout, .hresp, .gate_pin, .tmr_overflow_in, .period_match_in,
   .count_en, .gate_level);
`default_nettype wire
